// ==== frf_defines.svh ====
// register offsets, bit positions, reset values and timing for the fault manager
`ifndef FRF_DEFINES_SVH
`define FRF_DEFINES_SVH
`define FRF_ADDR_W 8
`define FRF_OFS_STATUS 8'h00
`define FRF_OFS_CTRL 8'h04
`define FRF_ST_FAULT_A 0
`define FRF_ST_FAULT_B 1
`define FRF_ST_TRAP 2
`define FRF_ST_GLOBAL 3
`define FRF_ST_MASTER 4
`define FRF_ST_WR_EN 5
`define FRF_CT_FORCE_A 0
`define FRF_CT_FORCE_B 1
`define FRF_CT_TRAP 6
`define FRF_CT_LRST 7
`define FRF_CTRL_RST 8'h00
`define FRF_READY_RST 1'b1
`define FRF_TX_EN_RST 2'h3
`define FRF_LATCH_RST 2'h3
`define FRF_FAIL_RST 2'h0
`define FRF_RESP_OKAY 2'h0
`define FRF_RESP_SLVERR 2'h2
`define FRF_CNT_W 8
`define FRF_DETECT_NS 1000
`define FRF_CLK_NS 20
`define FRF_DETECT_CYC (`FRF_DETECT_NS / `FRF_CLK_NS)
`endif

// ==== frf_pkg.sv ====
// types shared by the fault manager
`include "frf_defines.svh"
package frf_pkg;
    // whole module state, registered in one place
    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic aw_got;
        logic w_got;
        logic [`FRF_ADDR_W-1:0] awaddr;
        logic [7:0] wbyte;
        logic wlane0;
        logic [7:0] ctrl;
        logic pb_meta;
        logic pb_sync;
        logic pb_prev;
        logic lrst_prev;
        logic rst_req;
        logic [1:0][`FRF_CNT_W-1:0] cnt;
        logic [1:0] fail;
        logic [1:0] latched;
        logic [1:0] fault;
        logic [1:0] tx_en;
        logic [1:0] force_err;
        logic [1:0] relay;
        logic global_err;
        logic trap_mode;
        logic net_trap_out;
        logic net_reset_out;
    } frf_state_t;
endpackage : frf_pkg

// ==== frf_fault_manager.sv ====
// two-channel ring fault manager with axi4-lite status and control
// Notes on behaviour
// - receive failure sets channel status bit 0/1, except on the standalone build
// - receive failure disables same channel transmit
// - standalone build reports faults on relay contacts
// - default mode recovers automatically when fault clears
// - trap mode by switch or control bit 6 on the ring master
// - master trap selection spreads to whole ring
// - master on open bus raises global error
// - trap mode holds failure until latch reset
// - power-up in trap mode latches both channels
// - pushbutton or bit toggle resets latch ring-wide
// - every latch reset re-arms trapping
// - bank b switches 3/4 force transmit errors
// - control bits 0/1 force transmit errors
// - control writes ignored unless write enabled
// - status bits read one when active
// - write enable switch gates the control byte
//
// Register access over AXI4-Lite and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "frf_defines.svh"
module frf_fault_manager #(
    parameter int DETECT_CYC = `FRF_DETECT_CYC // qualify time for a change
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic awvalid,
    output logic awready,
    input wire logic [`FRF_ADDR_W-1:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    input wire logic arvalid,
    output logic arready,
    input wire logic [`FRF_ADDR_W-1:0] araddr,
    input wire logic [2:0] arprot,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    input wire logic rx_a_signal_ok,
    input wire logic rx_b_signal_ok,
    input wire logic sw_a_write_en,
    input wire logic sw_b_trap,
    input wire logic sw_b_force_a,
    input wire logic sw_b_force_b,
    input wire logic is_net_master,
    input wire logic redundant_ring,
    input wire logic standalone_variant,
    input wire logic latch_reset_pushbutton,
    input wire logic net_trap_in,
    input wire logic net_reset_in,
    output logic tx_a_enable,
    output logic tx_b_enable,
    output logic tx_a_force_error,
    output logic tx_b_force_error,
    output logic chan_a_error_led,
    output logic chan_b_error_led,
    output logic fault_relay_connector_a,
    output logic fault_relay_connector_b,
    output logic global_error_led,
    output logic net_trap_out,
    output logic net_reset_out
);
    import frf_pkg::*;

    localparam logic [`FRF_CNT_W-1:0] CNT_LAST = `FRF_CNT_W'(DETECT_CYC - 1);

    frf_state_t q; // current state
    frf_state_t next_q; // next state
    logic [1:0] rx_ok; // receive inputs as a vector
    logic [7:0] ctrl_eff; // control byte as seen by the logic
    logic trap_local; // trap selected on this module
    logic local_rst; // reset request raised here

    // map an address to a register, shared by read and write paths
    function automatic logic [1:0] reg_sel(input logic [`FRF_ADDR_W-1:0] a);
        reg_sel = 2'h0;
        if (a == `FRF_OFS_STATUS) begin
            reg_sel = 2'h1;
        end else if (a == `FRF_OFS_CTRL) begin
            reg_sel = 2'h2;
        end
    endfunction : reg_sel

    assign rx_ok = {rx_b_signal_ok, rx_a_signal_ok};

    // control byte is dead while host writes are off
    assign ctrl_eff = sw_a_write_en ? q.ctrl : `FRF_CTRL_RST;
    assign trap_local = is_net_master & (sw_b_trap | ctrl_eff[`FRF_CT_TRAP]);
    // a pushbutton edge or any change of the reset bit is one request
    assign local_rst = (q.pb_sync & ~q.pb_prev)
        | (ctrl_eff[`FRF_CT_LRST] ^ q.lrst_prev);

    // all next-state logic
    always_comb begin
        logic [1:0] sel;
        logic [1:0] fault_n;
        sel = 2'h0;
        fault_n = 2'h0;
        next_q = q;

        // write channel: address and data taken in either order
        if (awvalid && q.awready) begin
            next_q.awaddr = awaddr;
            next_q.aw_got = 1'b1;
            next_q.awready = 1'b0;
        end
        if (wvalid && q.wready) begin
            next_q.wbyte = wdata[7:0];
            next_q.wlane0 = wstrb[0];
            next_q.w_got = 1'b1;
            next_q.wready = 1'b0;
        end
        // both halves in hand: commit and answer
        if (q.aw_got && q.w_got && !q.bvalid) begin
            sel = reg_sel(q.awaddr);
            next_q.aw_got = 1'b0;
            next_q.w_got = 1'b0;
            next_q.bvalid = 1'b1;
            next_q.bresp = (sel == 2'h0) ? `FRF_RESP_SLVERR : `FRF_RESP_OKAY;
            // writes without the switch are accepted but dropped
            if (sel == 2'h2 && q.wlane0 && sw_a_write_en) begin
                next_q.ctrl = q.wbyte;
            end
        end
        // response taken: open for the next write
        if (q.bvalid && bready) begin
            next_q.bvalid = 1'b0;
            next_q.awready = 1'b1;
            next_q.wready = 1'b1;
        end

        // read channel
        if (arvalid && q.arready) begin
            sel = reg_sel(araddr);
            next_q.arready = 1'b0;
            next_q.rvalid = 1'b1;
            next_q.rresp = (sel == 2'h0) ? `FRF_RESP_SLVERR : `FRF_RESP_OKAY;
            next_q.rdata = 32'h0;
            case (sel)
                2'h1: begin
                    // relay builds report on contacts, not status bits
                    next_q.rdata[`FRF_ST_FAULT_A] = q.fault[0] & ~standalone_variant;
                    next_q.rdata[`FRF_ST_FAULT_B] = q.fault[1] & ~standalone_variant;
                    next_q.rdata[`FRF_ST_TRAP] = q.trap_mode;
                    next_q.rdata[`FRF_ST_GLOBAL] = q.global_err;
                    next_q.rdata[`FRF_ST_MASTER] = is_net_master;
                    next_q.rdata[`FRF_ST_WR_EN] = sw_a_write_en;
                end
                2'h2: begin
                    next_q.rdata[7:0] = ctrl_eff; // reads zero when writes are off
                end
                default: begin
                    next_q.rdata = 32'h0;
                end
            endcase
        end
        if (q.rvalid && rready) begin
            next_q.rvalid = 1'b0;
            next_q.arready = 1'b1;
        end

        // pushbutton synchroniser; only the second stage is looked at
        next_q.pb_meta = latch_reset_pushbutton;
        next_q.pb_sync = q.pb_meta;
        next_q.pb_prev = q.pb_sync;
        next_q.lrst_prev = ctrl_eff[`FRF_CT_LRST];
        // a request from the ring counts like a local one
        next_q.rst_req = local_rst | net_reset_in;
        next_q.net_reset_out = local_rst;

        // trap mode from this master or from the ring master
        next_q.net_trap_out = trap_local;
        next_q.trap_mode = trap_local | net_trap_in;

        // per-channel failure qualification; a short glitch is filtered
        for (int i = 0; i < 2; i++) begin
            if (rx_ok[i] != q.fail[i]) begin
                next_q.cnt[i] = '0; // input agrees with the state
            end else if (q.cnt[i] == CNT_LAST) begin
                next_q.cnt[i] = '0;
                next_q.fail[i] = ~q.fail[i];
            end else begin
                next_q.cnt[i] = q.cnt[i] + `FRF_CNT_W'(1);
            end
        end

        // latch: a new failure wins over a reset in the same cycle
        // hold also while trap mode is only about to come up, since the
        // registered mode is still low on the first edge after reset and
        // the power-up trapped state would otherwise be lost
        if (q.trap_mode || next_q.trap_mode) begin
            next_q.latched = q.fail | (q.latched & ~{2{q.rst_req}});
        end else begin
            next_q.latched = q.fail; // auto recovery just follows
        end
        fault_n = q.trap_mode ? next_q.latched : q.fail;

        next_q.fault = fault_n;
        next_q.tx_en = ~fault_n;
        next_q.relay = standalone_variant ? fault_n : 2'h0;
        next_q.force_err[0] = sw_b_force_a | ctrl_eff[`FRF_CT_FORCE_A];
        next_q.force_err[1] = sw_b_force_b | ctrl_eff[`FRF_CT_FORCE_B];
        // an open bus cannot close the ring, so a master flags it
        next_q.global_err = is_net_master & ~redundant_ring;
    end

    // state register, synchronous reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= '0;
            q.ctrl <= `FRF_CTRL_RST;
            q.fail <= `FRF_FAIL_RST;
            q.latched <= `FRF_LATCH_RST;
            q.tx_en <= `FRF_TX_EN_RST;
            // bus opens for the first request straight after reset
            q.awready <= `FRF_READY_RST;
            q.wready <= `FRF_READY_RST;
            q.arready <= `FRF_READY_RST;
        end else begin
            q <= next_q;
        end
    end

    // outputs straight from flops
    assign awready = q.awready;
    assign wready = q.wready;
    assign bvalid = q.bvalid;
    assign bresp = q.bresp;
    assign arready = q.arready;
    assign rvalid = q.rvalid;
    assign rdata = q.rdata;
    assign rresp = q.rresp;
    assign tx_a_enable = q.tx_en[0];
    assign tx_b_enable = q.tx_en[1];
    assign tx_a_force_error = q.force_err[0];
    assign tx_b_force_error = q.force_err[1];
    assign chan_a_error_led = q.fault[0];
    assign chan_b_error_led = q.fault[1];
    assign fault_relay_connector_a = q.relay[0];
    assign fault_relay_connector_b = q.relay[1];
    assign global_error_led = q.global_err;
    assign net_trap_out = q.net_trap_out;
    assign net_reset_out = q.net_reset_out;

    // checks
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence s_press;
        q.pb_sync && !q.pb_prev;
    endsequence
    sequence s_trapped_a;
        q.trap_mode && q.latched[0] && !q.rst_req;
    endsequence

    chk_fail_cause: assert property ($rose(q.fail[0]) |-> $past(!rx_a_signal_ok))
        else $error("channel a failed without loss of signal");
    chk_tx_off_fault: assert property (tx_a_enable == !chan_a_error_led && tx_b_enable == !chan_b_error_led)
        else $error("transmit enable disagrees with fault");
    chk_relay_gate: assert property (!standalone_variant |=> !fault_relay_connector_a && !fault_relay_connector_b)
        else $error("relay driven on plug-in build");
    chk_trap_hold: assert property (s_trapped_a |=> q.latched[0])
        else $error("trapped failure released without reset");
    chk_rearm_clear: assert property (q.trap_mode && q.rst_req && !q.fail[0] |=> !q.latched[0])
        else $error("latch reset did not clear channel a");
    chk_press_request: assert property (s_press |=> q.rst_req && q.pb_prev && q.net_reset_out)
        else $error("pushbutton press lost");
    chk_force_sw: assert property (sw_b_force_a |=> tx_a_force_error)
        else $error("switch force on channel a missing");
    chk_wr_blocked: assert property (!sw_a_write_en |=> $stable(q.ctrl))
        else $error("control changed with writes disabled");
    chk_ring_trap: assert property (net_trap_in |=> q.trap_mode)
        else $error("ring trap not followed");
    chk_global_err: assert property (is_net_master && !redundant_ring |=> global_error_led)
        else $error("global error missing on open bus master");
    chk_auto_follow: assert property (!q.trap_mode && !$past(q.trap_mode) |-> q.fault == $past(q.fail))
        else $error("auto mode fault does not follow failure");
    // a qualified failure always turns the transmitter off next cycle
    chk_fail_tx_b: assert property (q.fail[1] |=> !tx_b_enable && chan_b_error_led)
        else $error("channel b transmitter left on after failure");
    // relay builds carry the failure on the contact
    chk_relay_follow: assert property (standalone_variant && q.fail[0] |=> fault_relay_connector_a)
        else $error("relay contact a missing on failure");
    // no new write is taken while a response is pending
    chk_write_busy: assert property (bvalid |-> !awready && !wready)
        else $error("write channel open while response pending");
    chk_read_busy: assert property (rvalid |-> !arready)
        else $error("read channel open while data pending");
    // answers stand unchanged until the master takes them
    chk_resp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped before taken");
    chk_rdata_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data dropped before taken");
endmodule : frf_fault_manager

// ==== frf_ring_neighbor.sv ====
// ring neighbour model: the light it sends into one receive input
`timescale 1ns/1ps
module frf_ring_neighbor #(
    parameter int LAG = 1 // reaction delay in cycles, 7 at most
) (
    input wire logic aclk,
    input wire logic cut, // bench breaks the fiber
    output logic rx_ok // valid light at our receiver
);
    logic [7:0] hist = 8'hff; // light history, starts lit
    // light drops and returns only after the lag, so a slow partner is modelled too
    always @(posedge aclk) begin
        hist <= {hist[6:0], !cut};
    end
    assign rx_ok = hist[LAG];
endmodule : frf_ring_neighbor

// ==== testbench.sv ====
// self-checking bench for the ring fault manager
`timescale 1ns/1ps
`include "frf_defines.svh"
module testbench;
    localparam int DET = 4; // short qualify count keeps the run brief
    localparam int SETTLE = 2 * DET + 12; // detect path plus partner lag
    localparam logic [7:0] ST = `FRF_OFS_STATUS;
    localparam logic [7:0] CT = `FRF_OFS_CTRL;
    typedef struct {string name; logic [33:0] val; logic [33:0] msk;} frf_note_t;
    frf_note_t notes[$]; // expected results, oldest first
    int num_errors = 0;
    int tests_run = 0;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, probe, cut_a, cut_b;
    logic awready, wready, bvalid, arready, rvalid, rx_a_signal_ok, rx_b_signal_ok;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [1:0] bresp, rresp;
    logic sw_a_write_en, sw_b_trap, sw_b_force_a, sw_b_force_b, is_net_master;
    logic redundant_ring, standalone_variant, latch_reset_pushbutton, net_trap_in, net_reset_in;
    logic tx_a_enable, tx_b_enable, tx_a_force_error, tx_b_force_error, chan_a_error_led;
    logic chan_b_error_led, fault_relay_connector_a, fault_relay_connector_b, global_error_led;
    logic net_trap_out, net_reset_out;
    int resets_seen = 0; // ring reset pulses sent by this module
    logic [9:0] obs; // leds b a, tx on b a, forcing b a, relays b a, global, trap out
    assign obs = {chan_b_error_led, chan_a_error_led, tx_b_enable, tx_a_enable,
        tx_b_force_error, tx_a_force_error, fault_relay_connector_b, fault_relay_connector_a,
        global_error_led, net_trap_out};
    frf_fault_manager #(.DETECT_CYC(DET)) u_frf_fault_manager (
        .aclk, .aresetn, .awvalid, .awready, .awaddr, .awprot(3'h0), .wvalid, .wready, .wdata,
        .wstrb(4'hf), .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .arprot(3'h0),
        .rvalid, .rready, .rdata, .rresp, .rx_a_signal_ok, .rx_b_signal_ok, .sw_a_write_en,
        .sw_b_trap, .sw_b_force_a, .sw_b_force_b, .is_net_master, .redundant_ring,
        .standalone_variant, .latch_reset_pushbutton, .net_trap_in, .net_reset_in,
        .tx_a_enable, .tx_b_enable, .tx_a_force_error, .tx_b_force_error, .chan_a_error_led,
        .chan_b_error_led, .fault_relay_connector_a, .fault_relay_connector_b,
        .global_error_led, .net_trap_out, .net_reset_out);
    // prompt partner on channel a, slow one on channel b
    frf_ring_neighbor #(.LAG(1)) u_nb_a (.aclk, .cut(cut_a), .rx_ok(rx_a_signal_ok));
    frf_ring_neighbor #(.LAG(6)) u_nb_b (.aclk, .cut(cut_b), .rx_ok(rx_b_signal_ok));
    // 50 mhz clock
    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end
    // compare each result with the oldest note
    always @(posedge aclk) begin
        if ((bvalid && bready) || (rvalid && rready) || probe) begin
            check(bvalid ? {bresp, 32'h0} : rvalid ? {rresp, rdata} : {24'h0, obs});
        end
    end
    // count one-cycle latch reset pulses handed on to the ring
    always @(posedge aclk) begin
        if (aresetn === 1'b1 && net_reset_out === 1'b1) begin
            resets_seen++;
        end
    end
    task automatic check(input logic [33:0] seen);
        frf_note_t n;
        n = notes.pop_front();
        tests_run++;
        if ((seen & n.msk) !== n.val) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", n.name, n.val, seen & n.msk);
        end
    endtask : check
    task automatic finish_test();
        $display("checks %0d errors %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : finish_test
    // watchdog: whole run is under a thousand cycles
    initial begin
        repeat (20000) @(posedge aclk);
        num_errors++;
        $display("ERROR watchdog expected end seen hang");
        finish_test();
    end
    task automatic reset_dut();
        aresetn <= 1'b0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
    endtask : reset_dut
    // one write; address and data offered together, each released when taken
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bit ad;
        bit dd;
        ad = 1'b0;
        dd = 1'b0;
        @(posedge aclk);
        notes.push_back('{"bresp", {`FRF_RESP_OKAY, 32'h0}, '1});
        awaddr <= a;
        wdata <= {24'($urandom), d}; // upper lanes are ignored
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(ad && dd)) begin
            @(posedge aclk);
            if (!ad && awready) begin
                ad = 1'b1;
                awvalid <= 1'b0;
            end
            if (!dd && wready) begin
                dd = 1'b1;
                wvalid <= 1'b0;
            end
        end
        while (!bvalid) @(posedge aclk);
        bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r = 2'h0);
        @(posedge aclk);
        notes.push_back('{"rdata", {r, 24'h0, d}, '1});
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        while (!rvalid) @(posedge aclk);
        rready <= 1'b0;
    endtask : rd
    // let the fault path settle, then sample the outputs once
    task automatic outs(input logic [9:0] v, input logic [9:0] m);
        repeat (SETTLE) @(posedge aclk);
        notes.push_back('{"outputs", {24'h0, v}, {24'h0, m}});
        probe <= 1'b1;
        @(posedge aclk);
        probe <= 1'b0;
    endtask : outs
    initial begin
        int g;
        logic [1:0] sw;
        logic [1:0] c;
        void'($urandom(32'h255d3046));
        {awvalid, wvalid, bready, arvalid, rready, probe, cut_a, cut_b} <= '0;
        {sw_b_trap, sw_b_force_a, sw_b_force_b, is_net_master, standalone_variant} <= '0;
        {latch_reset_pushbutton, net_trap_in, net_reset_in, awaddr, araddr, wdata} <= '0;
        {sw_a_write_en, redundant_ring} <= 2'h3;
        reset_dut();
        rd(ST, 8'h20);
        rd(8'h08, 8'h00, `FRF_RESP_SLVERR);
        wr(ST, 8'h03);
        rd(CT, `FRF_CTRL_RST);
        // break each fiber, then mend it
        for (int i = 0; i < 2; i++) begin
            {cut_b, cut_a} <= 2'(1 << i);
            outs(10'h0c0 ^ (10'h140 << i), '1);
            rd(ST, 8'h20 | 8'(1 << i));
            {cut_b, cut_a} <= 2'h0;
            outs(10'h0c0, '1);
        end
        g = 1 + $urandom % (DET - 1);
        cut_a <= 1'b1;
        repeat (g) @(posedge aclk);
        cut_a <= 1'b0;
        outs(10'h0c0, '1);
        // switches and control bits both force errors
        for (int i = 0; i < 8; i++) begin
            sw = 2'($urandom);
            c = 2'($urandom);
            {sw_b_force_b, sw_b_force_a} <= sw;
            wr(CT, {6'h0, c});
            outs(10'h0c0 | {4'h0, sw | c, 4'h0}, '1);
            rd(CT, {6'h0, c});
        end
        {sw_b_force_b, sw_b_force_a} <= 2'h0;
        wr(CT, 8'h00);
        sw_a_write_en <= 1'b0;
        wr(CT, 8'h43);
        outs(10'h0c0, '1);
        rd(ST, 8'h00);
        rd(CT, 8'h00);
        sw_a_write_en <= 1'b1;
        {is_net_master, redundant_ring} <= 2'h2;
        outs(10'h0c2, '1);
        rd(ST, 8'h38);
        redundant_ring <= 1'b1;
        sw_b_trap <= 1'b1; // lone ring master with trap selected
        reset_dut();
        outs(10'h301, 10'h301);
        latch_reset_pushbutton <= 1'b1;
        repeat (4) @(posedge aclk);
        latch_reset_pushbutton <= 1'b0;
        outs(10'h0c1, '1);
        cut_a <= 1'b1;
        outs(10'h181, '1);
        cut_a <= 1'b0;
        outs(10'h181, '1);
        wr(CT, 8'h80);
        outs(10'h0c1, '1);
        cut_b <= 1'b1;
        repeat (SETTLE) @(posedge aclk);
        cut_b <= 1'b0;
        outs(10'h241, '1);
        wr(CT, 8'h00);
        outs(10'h0c1, '1);
        sw_b_trap <= 1'b0;
        wr(CT, 8'h40);
        rd(ST, 8'h34);
        outs(10'h0c1, '1);
        wr(CT, 8'h00);
        is_net_master <= 1'b0;
        net_trap_in <= 1'b1;
        rd(ST, 8'h24);
        cut_a <= 1'b1;
        repeat (SETTLE) @(posedge aclk);
        cut_a <= 1'b0;
        outs(10'h180, '1);
        net_reset_in <= 1'b1;
        @(posedge aclk);
        net_reset_in <= 1'b0;
        outs(10'h0c0, '1);
        net_trap_in <= 1'b0;
        standalone_variant <= 1'b1;
        cut_a <= 1'b1;
        outs(10'h084, 10'h0fc);
        rd(ST, 8'h20);
        cut_a <= 1'b0;
        outs(10'h0c0, 10'h0fc);
        // one press and two reset-bit changes; ring requests are not echoed
        tests_run++;
        if (resets_seen != 3) begin
            num_errors++;
            $display("ERROR net_reset_out pulses expected 3 seen %0d", resets_seen);
        end
        finish_test();
    end
endmodule : testbench
